// ===== hdl/per_output_pwm_intensity.v
// per-output pwm intensity registers and pwm generation for eight ports
// assumes a serial bus decoder presents byte writes/reads synchronous to REF_CLK_I
`timescale 1ns/100ps
`include "pwm_intensity_defs.vh"

module per_output_pwm_intensity #(
  parameter SLOT_DIV = `SLOT_DIV_DEFAULT
) (
  // clock and reset
  input wire REF_CLK_I,
  input wire RST_B_I,
  // register access from the serial decoder
  input wire [7:0] REG_ADDR_I,
  input wire [7:0] REG_WDATA_I,
  input wire REG_WR_I,
  input wire REG_RD_I,
  output reg [7:0] REG_RDATA_O,
  output reg REG_RVALID_O,
  // output levels: 1 = sinking (led lit)
  input wire [7:0] PORT_LEVEL_I,
  input wire NINTH_LEVEL_I,
  // open-drain drive enables
  output reg [7:0] OUTPUT_PORT_OE_O,
  output reg NINTH_OUTPUT_OE_O
);

  // register bank
  reg [7:0] port_pair_0_1_intensity_reg;
  reg [7:0] port_pair_2_3_intensity_reg;
  reg [7:0] port_pair_4_5_intensity_reg;
  reg [7:0] port_pair_6_7_intensity_reg;
  reg [7:0] master_intensity_reg;
  // next values of the bank and of the registered outputs
  reg [7:0] port_pair_0_1_intensity_next;
  reg [7:0] port_pair_2_3_intensity_next;
  reg [7:0] port_pair_4_5_intensity_next;
  reg [7:0] port_pair_6_7_intensity_next;
  reg [7:0] master_intensity_next;
  reg [7:0] rdata_next;
  reg rvalid_next;
  reg [7:0] port_oe_next;
  reg ninth_oe_next;
  // decoded write and read requests
  reg [`SEL_W-1:0] wr_sel;
  reg [`SEL_W-1:0] rd_sel;
  // intensity code of each output
  wire [`CODE_W-1:0] code_port_0;
  wire [`CODE_W-1:0] code_port_1;
  wire [`CODE_W-1:0] code_port_2;
  wire [`CODE_W-1:0] code_port_3;
  wire [`CODE_W-1:0] code_port_4;
  wire [`CODE_W-1:0] code_port_5;
  wire [`CODE_W-1:0] code_port_6;
  wire [`CODE_W-1:0] code_port_7;
  wire [`CODE_W-1:0] code_ninth;
  // shared slot count and oscillator gate
  wire [`CODE_W-1:0] slot;
  wire run;

  // one-hot select of the addressed register; zero when unmapped
  function [`SEL_W-1:0] reg_select;
    input [7:0] addr;
    begin
      if (addr == `ADDR_PAIR_0_1)
        reg_select = `SEL_PAIR_0_1;
      else if (addr == `ADDR_PAIR_2_3)
        reg_select = `SEL_PAIR_2_3;
      else if (addr == `ADDR_PAIR_4_5)
        reg_select = `SEL_PAIR_4_5;
      else if (addr == `ADDR_PAIR_6_7)
        reg_select = `SEL_PAIR_6_7;
      else if (addr == `ADDR_MASTER)
        reg_select = `SEL_MASTER;
      else
        reg_select = `SEL_NONE;
    end
  endfunction

  // duty test for one code against the current slot
  function active;
    input [3:0] code;
    input [3:0] s;
    input en;
    begin
      if (!en || code == `CODE_STATIC)
        active = 1'b1;
      else
        active = (s <= code);
    end
  endfunction

  // both strobes share one address decode
  always @* begin
    wr_sel = REG_WR_I ? reg_select(REG_ADDR_I) : `SEL_NONE;
    rd_sel = REG_RD_I ? reg_select(REG_ADDR_I) : `SEL_NONE;
  end

  // write path; unmapped writes leave the bank alone
  always @* begin
    port_pair_0_1_intensity_next = port_pair_0_1_intensity_reg;
    port_pair_2_3_intensity_next = port_pair_2_3_intensity_reg;
    port_pair_4_5_intensity_next = port_pair_4_5_intensity_reg;
    port_pair_6_7_intensity_next = port_pair_6_7_intensity_reg;
    master_intensity_next = master_intensity_reg;
    if (wr_sel[`SEL_BIT_PAIR_0_1])
      port_pair_0_1_intensity_next = REG_WDATA_I;
    if (wr_sel[`SEL_BIT_PAIR_2_3])
      port_pair_2_3_intensity_next = REG_WDATA_I;
    if (wr_sel[`SEL_BIT_PAIR_4_5])
      port_pair_4_5_intensity_next = REG_WDATA_I;
    if (wr_sel[`SEL_BIT_PAIR_6_7])
      port_pair_6_7_intensity_next = REG_WDATA_I;
    if (wr_sel[`SEL_BIT_MASTER])
      master_intensity_next = REG_WDATA_I;
  end

  // readback same layout
  // a read in the cycle of a write still sees the old contents
  always @* begin
    rvalid_next = REG_RD_I;
    if (!REG_RD_I)
      rdata_next = REG_RDATA_O;
    else if (rd_sel[`SEL_BIT_PAIR_0_1])
      rdata_next = port_pair_0_1_intensity_reg;
    else if (rd_sel[`SEL_BIT_PAIR_2_3])
      rdata_next = port_pair_2_3_intensity_reg;
    else if (rd_sel[`SEL_BIT_PAIR_4_5])
      rdata_next = port_pair_4_5_intensity_reg;
    else if (rd_sel[`SEL_BIT_PAIR_6_7])
      rdata_next = port_pair_6_7_intensity_reg;
    else if (rd_sel[`SEL_BIT_MASTER])
      rdata_next = master_intensity_reg;
    else
      rdata_next = `READ_UNMAPPED;
  end

  assign code_port_0 = port_pair_0_1_intensity_reg[`LO_NIB];
  assign code_port_1 = port_pair_0_1_intensity_reg[`HI_NIB];
  assign code_port_2 = port_pair_2_3_intensity_reg[`LO_NIB];
  assign code_port_3 = port_pair_2_3_intensity_reg[`HI_NIB];
  assign code_port_4 = port_pair_4_5_intensity_reg[`LO_NIB];
  assign code_port_5 = port_pair_4_5_intensity_reg[`HI_NIB];
  assign code_port_6 = port_pair_6_7_intensity_reg[`LO_NIB];
  assign code_port_7 = port_pair_6_7_intensity_reg[`HI_NIB];
  assign code_ninth = master_intensity_reg[`LO_NIB];
  assign run = (master_intensity_reg[`HI_NIB] != `MASTER_OFF);

  slot_counter #(
    .DIV(SLOT_DIV)
  ) u_slot (
    .clk_i(REF_CLK_I),
    .rst_b_i(RST_B_I),
    .run_i(run),
    .slot_o(slot),
    .wrap_o()
  );

  always @* begin
    port_oe_next[0] = PORT_LEVEL_I[0] & active(code_port_0, slot, run);
    port_oe_next[1] = PORT_LEVEL_I[1] & active(code_port_1, slot, run);
    port_oe_next[2] = PORT_LEVEL_I[2] & active(code_port_2, slot, run);
    port_oe_next[3] = PORT_LEVEL_I[3] & active(code_port_3, slot, run);
    port_oe_next[4] = PORT_LEVEL_I[4] & active(code_port_4, slot, run);
    port_oe_next[5] = PORT_LEVEL_I[5] & active(code_port_5, slot, run);
    port_oe_next[6] = PORT_LEVEL_I[6] & active(code_port_6, slot, run);
    port_oe_next[7] = PORT_LEVEL_I[7] & active(code_port_7, slot, run);
    ninth_oe_next = NINTH_LEVEL_I & active(code_ninth, slot, run);
  end

  // register bank update
  always @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      port_pair_0_1_intensity_reg <= `RST_INTENSITY;
      port_pair_2_3_intensity_reg <= `RST_INTENSITY;
      port_pair_4_5_intensity_reg <= `RST_INTENSITY;
      port_pair_6_7_intensity_reg <= `RST_INTENSITY;
      master_intensity_reg <= `RST_MASTER;
    end else begin
      port_pair_0_1_intensity_reg <= port_pair_0_1_intensity_next;
      port_pair_2_3_intensity_reg <= port_pair_2_3_intensity_next;
      port_pair_4_5_intensity_reg <= port_pair_4_5_intensity_next;
      port_pair_6_7_intensity_reg <= port_pair_6_7_intensity_next;
      master_intensity_reg <= master_intensity_next;
    end
  end

  // read answer; data holds until the next read
  always @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      REG_RDATA_O <= `READ_UNMAPPED;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RDATA_O <= rdata_next;
      REG_RVALID_O <= rvalid_next;
    end
  end

  // drive enables, one cycle behind the slot count
  always @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      OUTPUT_PORT_OE_O <= `OE_IDLE;
      NINTH_OUTPUT_OE_O <= 1'b0;
    end else begin
      OUTPUT_PORT_OE_O <= port_oe_next;
      NINTH_OUTPUT_OE_O <= ninth_oe_next;
    end
  end

endmodule // per_output_pwm_intensity

// ===== hdl/pwm_intensity_defs.vh
// constants for the per-output pwm intensity block
// included by the design files; definitions only
`ifndef PWM_INTENSITY_DEFS_VH
`define PWM_INTENSITY_DEFS_VH

// register addresses
`define ADDR_PAIR_0_1 8'h10
`define ADDR_PAIR_2_3 8'h11
`define ADDR_PAIR_4_5 8'h12
`define ADDR_PAIR_6_7 8'h13
`define ADDR_MASTER 8'h0E
// field layout
`define CODE_W 4
`define LO_NIB 3:0
`define HI_NIB 7:4
// codes and reset values
`define CODE_STATIC 4'hF
`define MASTER_OFF 4'h0
`define RST_INTENSITY 8'h00
`define RST_MASTER 8'h00
`define READ_UNMAPPED 8'h00
`define OE_IDLE 8'h00
// one-hot register select: bit positions and codes
`define SEL_W 5
`define SEL_BIT_PAIR_0_1 0
`define SEL_BIT_PAIR_2_3 1
`define SEL_BIT_PAIR_4_5 2
`define SEL_BIT_PAIR_6_7 3
`define SEL_BIT_MASTER 4
`define SEL_NONE 5'h00
`define SEL_PAIR_0_1 5'h01
`define SEL_PAIR_2_3 5'h02
`define SEL_PAIR_4_5 5'h04
`define SEL_PAIR_6_7 5'h08
`define SEL_MASTER 5'h10
// last slot of the pwm period
`define SLOT_LAST 4'hF
// default oscillator divider: pwm slot length in ref clocks
`define SLOT_DIV_DEFAULT 16'h0001

`endif

// ===== hdl/slot_counter.v
// shared 16-slot pwm period counter
// assumes a single clock; runs only while enabled
`timescale 1ns/100ps
`include "pwm_intensity_defs.vh"

module slot_counter #(
  parameter DIV = `SLOT_DIV_DEFAULT
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire run_i,
  output reg [3:0] slot_o,
  output reg wrap_o
);

  reg [15:0] div_reg;

  always @(posedge clk_i) begin
    if (!rst_b_i || !run_i) begin
      div_reg <= 16'h0000;
      slot_o <= 4'h0;
      wrap_o <= 1'b0;
    end else if (div_reg >= DIV - 16'h0001) begin
      div_reg <= 16'h0000;
      slot_o <= slot_o + 4'h1;
      wrap_o <= (slot_o == `SLOT_LAST);
    end else begin
      div_reg <= div_reg + 16'h0001;
      wrap_o <= 1'b0;
    end
  end

endmodule // slot_counter

// ===== verification/host_model.sv
// host model driving the register strobes of the block
// assumes the clock of the block; one transfer per call
`timescale 1ns/100ps
module host_model (
  // clock and read data
  input wire clk_i,
  input wire [7:0] rdata_i,
  // request lines
  output reg [7:0] addr_o = 8'h00,
  output reg [7:0] wdata_o = 8'h00,
  output reg wr_o = 1'b0,
  output reg rd_o = 1'b0
);
  task xfer(input w, input [7:0] a, input [7:0] d, output [7:0] q);
    begin
      @(posedge clk_i);
      {addr_o, wdata_o, wr_o, rd_o} <= {a, d, w, !w};
      @(posedge clk_i);
      {addr_o, wdata_o, wr_o, rd_o} <= {~a, ~d, 2'b00};
      #1 q = rdata_i;
    end
  endtask
endmodule // host_model

// ===== verification/pwm_intensity_sva.sv
// port checker for the intensity block
// assumes a slot length of one clock
`timescale 1ns/100ps
module pwm_intensity_sva (
  input wire REF_CLK_I, RST_B_I, REG_WR_I, REG_RD_I, REG_RVALID_O,
  input wire NINTH_LEVEL_I, NINTH_OUTPUT_OE_O,
  input wire [7:0] REG_ADDR_I, REG_WDATA_I, REG_RDATA_O, PORT_LEVEL_I, OUTPUT_PORT_OE_O
);
  reg [3:0] m_reg = 4'h0;
  wire map = REG_ADDR_I == 8'h0E || REG_ADDR_I[7:2] == 6'h04;
  always @(posedge REF_CLK_I)
    if (!RST_B_I)
      m_reg <= 4'h0;
    else if (REG_WR_I && REG_ADDR_I == 8'h0E)
      m_reg <= REG_WDATA_I[7:4];
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);
  a_rd_answer: assert property (REG_RD_I |=> REG_RVALID_O) else $error("no answer");
  a_no_stray: assert property (!REG_RD_I |=> !REG_RVALID_O) else $error("stray");
  a_rdata_hold: assert property (!REG_RVALID_O |-> $stable(REG_RDATA_O)) else $error("drift");
  a_unmapped_zero: assert property (REG_RD_I && !map |=> REG_RDATA_O == 8'h00)
    else $error("unmapped");
  a_read_back: assert property (REG_WR_I && map ##2 REG_RD_I
    && REG_ADDR_I == $past(REG_ADDR_I, 2) |=> REG_RDATA_O == $past(REG_WDATA_I, 3))
    else $error("readback");
  a_port_off: assert property ((OUTPUT_PORT_OE_O & ~$past(PORT_LEVEL_I)) == 8'h00)
    else $error("port lit");
  a_ninth_off: assert property (NINTH_OUTPUT_OE_O |-> $past(NINTH_LEVEL_I))
    else $error("ninth on");
  a_master_off: assert property (m_reg == 4'h0
    |=> OUTPUT_PORT_OE_O[0] == $past(PORT_LEVEL_I[0])) else $error("not static");
  cover property (REG_RD_I && !map);
  cover property (m_reg == 4'h0 && PORT_LEVEL_I[0]);
  cover property (m_reg != 4'h0 && OUTPUT_PORT_OE_O[0]);
endmodule // pwm_intensity_sva
bind per_output_pwm_intensity pwm_intensity_sva u_sva (.*);

// ===== verification/testbench.sv
// self-checking bench for the intensity block
// assumes host_model as register master
`timescale 1ns/100ps
module testbench;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [7:0] lvl = 8'h00;
  reg [7:0] q, d, lv;
  reg [7:0] pv [0:3];
  reg [3:0] code;
  wire [7:0] a, wd, rdat, oe;
  wire wr, rd, oe9;
  integer err_count = 0, checks = 0, cyc = 0, i, k;
  integer n [0:8];
  always #20 clk = ~clk;
  host_model h (.clk_i(clk), .rdata_i(rdat), .addr_o(a), .wdata_o(wd), .wr_o(wr), .rd_o(rd));
  per_output_pwm_intensity #(.SLOT_DIV(1)) dut (.REF_CLK_I(clk), .RST_B_I(rst_b),
    .REG_ADDR_I(a), .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat),
    .REG_RVALID_O(), .PORT_LEVEL_I(lvl), .NINTH_LEVEL_I(lvl[7]), .OUTPUT_PORT_OE_O(oe),
    .NINTH_OUTPUT_OE_O(oe9));
  function [7:0] duty(input [3:0] c, input run);
    duty = (c == 4'hF || !run) ? 8'h20 : {3'h0, c, 1'b0} + 8'h02;
  endfunction
  task chk(input [63:0] nm, input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("mismatch %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count = err_count + 1;
      conclude;
    end
  end
  initial begin
    q = $urandom(32'hc0fa37de);
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      d = $urandom;
      h.xfer(1'b1, 8'h10 + i[7:0], d, q);
      h.xfer(1'b0, 8'h10 + i[7:0], 8'h00, q);
      chk("rdbk", q, (i < 4) ? d : 8'h00);
    end
    for (i = 0; i < 17; i = i + 1) begin
      lv = (i % 4 == 0) ? 8'hFF : $urandom;
      @(posedge clk);
      lvl <= lv;
      d = (i < 16) ? {4'hF, i[3:0]} : 8'h00;
      h.xfer(1'b1, 8'h0E, d, q);
      h.xfer(1'b0, 8'h0E, 8'h00, q);
      chk("master", q, d);
      pv[0] = {~i[3:0], i[3:0]};
      for (k = 1; k < 4; k = k + 1)
        pv[k] = $urandom;
      for (k = 0; k < 4; k = k + 1)
        h.xfer(1'b1, 8'h10 + k[7:0], pv[k], q);
      for (k = 0; k < 9; k = k + 1)
        n[k] = 0;
      repeat (2) @(posedge clk);
      repeat (32) begin
        @(posedge clk);
        #1;
        for (k = 0; k < 8; k = k + 1)
          n[k] = n[k] + oe[k];
        n[8] = n[8] + oe9;
      end
      for (k = 0; k < 8; k = k + 1) begin
        code = k[0] ? pv[k / 2][7:4] : pv[k / 2][3:0];
        chk("port", n[k], lv[k] ? duty(code, i < 16) : 8'h00);
      end
      chk("ninth", n[8], lv[7] ? duty(i[3:0], i < 16) : 8'h00);
    end
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    h.xfer(1'b0, 8'h10, 8'h00, q);
    chk("rst", q, 8'h00);
    h.xfer(1'b1, 8'h11, 8'h5A, q);
    h.xfer(1'b0, 8'h11, 8'h00, q);
    chk("rdbk", q, 8'h5A);
    conclude;
  end
endmodule // testbench
